// ===== logic/acc_ident.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - attach on id or supply enters active
// - conclusion sets device type and attach flag
// - unidentified accessory sets unknown flag instead
// - debounced supply high raises detect, sense one
// - supply low raises detect at once, sense zero
// - debounce selector picks 0/10/20/30 ms
// - high and low threshold selectors, default 011
// - over-voltage during attach raises debounced flag
// - over-voltage debounce 0/2/4/8 rtc cycles
// - id open sense zero while resistor attached
// - id fall starts, rise detaches, done marks end
// - enable converter, store result, auto clear
// - result 00000 low resistance, 11111 floating
// - key held past 1.5 s flags stuck
// - stuck key release flags recovery, restarts id
// - supply detect starts delay before type check
// - id attached: await id, av ends sequence
// - type enable drives source dp, sink dm
// - dm in window 20 ms flags short
// - short with id attached disconnects, done
// - short with id open tries reverse, done
// - final type combines id and short results
module acc_ident #(
  parameter logic [15:0] STUCK_TICKS = acc_pkg::STUCK_DEF // key hold limit, rtc ticks
) (
  input logic CLK, // 50 MHz system clock
  input logic SYS_RST, // synchronous reset, active high
  input logic CE, // clock enable, all state frozen while low
  input logic RTC_CLK, // 32 kHz rtc clock, sampled as a level
  input logic [7:0] ADDR, // register byte address
  input logic [31:0] WDATA, // register write data
  input logic WR, // write strobe
  input logic RD, // read strobe
  output logic [31:0] RDATA, // read data, valid the cycle after RD
  input acc_pkg::sense_t SENSE_IN, // analog comparators and id converter
  output acc_pkg::drive_t DRIVE_OUT // analog enables and selectors
);
  import acc_pkg::*;

  typedef enum logic [4:0] {
    I_IDLE = 5'h01,
    I_CONV = 5'h02,
    I_KEY = 5'h04,
    I_JAM = 5'h08,
    I_DONE = 5'h10
  } id_st_t;

  typedef enum logic [5:0] {
    P_IDLE = 6'h01,
    P_DELAY = 6'h02,
    P_WAITID = 6'h04,
    P_FWD = 6'h08,
    P_REV = 6'h10,
    P_END = 6'h20
  } p_st_t;

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  sense_t s1_q;
  sense_t s2_q;
  logic rtc1_q;
  logic rtc2_q;
  logic rtc3_q;
  logic id_open_q;
  logic adc_prev_q;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s1_q <= SENSE_RST;
      s2_q <= SENSE_RST;
      rtc1_q <= 1'b0;
      rtc2_q <= 1'b0;
      rtc3_q <= 1'b0;
      id_open_q <= 1'b1;
      adc_prev_q <= 1'b0;
    end else if (CE) begin
      s1_q <= SENSE_IN;
      s2_q <= s1_q;
      rtc1_q <= RTC_CLK;
      rtc2_q <= rtc1_q;
      rtc3_q <= rtc2_q;
      id_open_q <= s2_q.id_open;
      adc_prev_q <= s2_q.adc_done;
    end
  end

  // one pulse per rtc period paces every interval counter
  wire tick = rtc2_q & ~rtc3_q;
  wire id_fall = id_open_q & ~s2_q.id_open;
  wire id_rise = ~id_open_q & s2_q.id_open;
  wire adc_rise = s2_q.adc_done & ~adc_prev_q;

  ////////////////////////////////////////////////////////////////////////////////
  // registers and state
  ctrl_t ctrl_q;
  logic [EV_W-1:0] ev_q;
  logic sense_q;
  logic [15:0] sdb_q;
  logic [15:0] ovp_cnt_q;
  logic ovp_hit_q;
  logic active_q;
  logic adc_st_q;
  logic [4:0] adc_res_q;
  id_st_t id_st_q;
  id_st_t id_d;
  logic [15:0] key_cnt_q;
  p_st_t p_st_q;
  p_st_t p_d;
  logic [15:0] p_cnt_q;
  logic [15:0] q_cnt_q;
  logic idw_q;
  logic fwd_q;
  logic rev_q;
  logic det_done_q;
  logic [3:0] dtype_q;

  ////////////////////////////////////////////////////////////////////////////////
  // supply attach debounce and over-voltage
  wire [15:0] db_need = db_ticks(ctrl_q.db);
  wire sdb_hit = s2_q.sup_hi & ~sense_q & (sdb_q >= db_need);
  wire sup_drop = s2_q.sup_lo & sense_q;
  wire sense_rise = sdb_hit & ~s2_q.sup_lo;
  wire sdet_ev = sense_rise | sup_drop;
  wire sdb_idle = ~s2_q.sup_hi | sense_q | s2_q.sup_lo;
  wire [15:0] ovp_need = ovp_ticks(ctrl_q.ovp_db);
  wire ovp_ev = s2_q.ovp & active_q & ~ovp_hit_q & (ovp_cnt_q >= ovp_need);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sense_q <= 1'b0;
      sdb_q <= 16'h0000;
      ovp_cnt_q <= 16'h0000;
      ovp_hit_q <= 1'b0;
    end else if (CE) begin
      if (sup_drop) begin
        sense_q <= 1'b0;
      end else if (sdb_hit) begin
        sense_q <= 1'b1;
      end
      sdb_q <= sdb_idle ? 16'h0000 : bump(sdb_q, tick);
      ovp_cnt_q <= s2_q.ovp ? bump(ovp_cnt_q, tick) : 16'h0000;
      // one event per over-voltage episode
      ovp_hit_q <= s2_q.ovp & (ovp_hit_q | ovp_ev);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // id identification and stuck key
  wire conv_done = (id_st_q == I_CONV) & adc_rise;
  wire conv_start = (id_d == I_CONV) & (id_st_q != I_CONV);
  wire [4:0] res_now = conv_done ? s2_q.adc_res : adc_res_q;
  wire jam_ev = (id_st_q == I_KEY) & (id_d == I_JAM);
  wire rcv_ev = (id_st_q == I_JAM) & (id_d == I_CONV);
  wire id_done_ev = (id_st_q == I_CONV) & (id_d == I_DONE);

  always_comb begin
    id_d = id_st_q;
    if (id_rise) begin
      id_d = I_IDLE;
    end else if (id_fall) begin
      id_d = I_CONV;
    end else begin
      unique case (id_st_q)
        I_IDLE: begin
        end
        I_CONV: begin
          if (adc_rise) begin
            id_d = is_key(s2_q.adc_res) ? I_KEY : I_DONE;
          end
        end
        I_KEY: begin
          if (!s2_q.key_held) begin
            id_d = I_CONV;
          end else if (key_cnt_q >= STUCK_TICKS) begin
            id_d = I_JAM;
          end
        end
        I_JAM: begin
          if (!s2_q.key_held) begin
            id_d = I_CONV;
          end
        end
        I_DONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      id_st_q <= I_IDLE;
      key_cnt_q <= 16'h0000;
      adc_st_q <= 1'b0;
      adc_res_q <= 5'h1F;
    end else if (CE) begin
      id_st_q <= id_d;
      key_cnt_q <= (id_st_q == I_KEY) ? bump(key_cnt_q, tick) : 16'h0000;
      adc_st_q <= conv_done | (adc_st_q & ~conv_start);
      // converter codes kept as delivered, 00000 shorted to 11111 open
      adc_res_q <= res_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // supply type sequence
  wire [15:0] td_need = td_ticks(ctrl_q.td);
  wire q_hit = q_cnt_q >= QUAL_TICKS;
  wire w_end = p_cnt_q >= WIN_TICKS;
  wire fwd_set = (p_st_q == P_FWD) & q_hit & sense_q;
  wire rev_set = (p_st_q == P_REV) & q_hit & sense_q;
  wire in_win = (p_st_q == P_FWD) ? s2_q.dm_win : s2_q.dp_win;
  wire av_ev = (p_st_q == P_WAITID) & (p_d == P_END);
  wire end_ev = ((p_st_q == P_FWD) | (p_st_q == P_REV)) & (p_d == P_END);
  wire id_only_ev = id_done_ev & (p_st_q == P_IDLE) & ~sense_q & ~sense_rise;
  wire conclude = end_ev | id_only_ev;
  wire [3:0] dt_new = decide(id_open_q, res_now, fwd_q | fwd_set, rev_q | rev_set);

  always_comb begin
    p_d = p_st_q;
    if (!sense_q && p_st_q != P_IDLE) begin
      p_d = P_IDLE;
    end else begin
      unique case (p_st_q)
        P_IDLE: begin
          if (sense_rise) begin
            p_d = P_DELAY;
          end
        end
        P_DELAY: begin
          if (p_cnt_q >= td_need) begin
            p_d = (idw_q | ~s2_q.id_open) ? P_WAITID : P_FWD;
          end
        end
        P_WAITID: begin
          if (id_st_q == I_DONE) begin
            p_d = (adc_res_q == ID_AV) ? P_END : P_FWD;
          end
        end
        P_FWD: begin
          if (q_hit) begin
            p_d = s2_q.id_open ? P_REV : P_END;
          end else if (w_end) begin
            p_d = P_END;
          end
        end
        P_REV: begin
          if (q_hit || w_end) begin
            p_d = P_END;
          end
        end
        P_END: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      p_st_q <= P_IDLE;
      p_cnt_q <= 16'h0000;
      q_cnt_q <= 16'h0000;
      idw_q <= 1'b0;
      fwd_q <= 1'b0;
      rev_q <= 1'b0;
      det_done_q <= 1'b0;
    end else if (CE) begin
      p_st_q <= p_d;
      p_cnt_q <= (p_d != p_st_q) ? 16'h0000 : bump(p_cnt_q, tick);
      // window qualification restarts whenever the line leaves the window
      if (p_d != p_st_q || !in_win) begin
        q_cnt_q <= 16'h0000;
      end else begin
        q_cnt_q <= bump(q_cnt_q, tick);
      end
      idw_q <= (p_d == P_DELAY) & (idw_q | ~s2_q.id_open);
      if (p_d == P_DELAY) begin
        fwd_q <= 1'b0;
        rev_q <= 1'b0;
        det_done_q <= 1'b0;
      end else begin
        fwd_q <= fwd_q | fwd_set;
        rev_q <= rev_q | rev_set;
        det_done_q <= det_done_q | end_ev;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // attach state, device type, events
  wire attach_ev = id_fall | sense_rise;
  wire active_d = attach_ev | (active_q & ~(id_open_q & ~sense_q));
  wire att_ev = av_ev | (conclude & (dt_new != DT_NONE));
  wire unk_ev = conclude & (dt_new == DT_NONE);
  wire sel_ctrl = ADDR == REG_CTRL;
  wire sel_stat = ADDR == REG_STAT;
  wire sel_evt = ADDR == REG_EVT;
  wire [EV_W-1:0] ev_set = {av_ev, rcv_ev, jam_ev, ovp_ev, sdet_ev, unk_ev, att_ev};
  wire [EV_W-1:0] ev_clr = (WR & sel_evt) ? WDATA[EV_W-1:0] : '0;
  stat_t stat;
  assign stat = {dtype_q, active_q, det_done_q, rev_q, fwd_q, adc_res_q, adc_st_q,
                 id_open_q, sense_q};
  wire [31:0] rd_mux = sel_ctrl ? {18'h0, ctrl_q} :
                       sel_stat ? {16'h0, stat} :
                       sel_evt ? {25'h0, ev_q} : 32'h0;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      active_q <= 1'b0;
      dtype_q <= DT_NONE;
      ev_q <= '0;
      ctrl_q <= CTRL_RST;
      RDATA <= 32'h0;
    end else if (CE) begin
      active_q <= active_d;
      if (av_ev) begin
        dtype_q <= DT_AV;
      end else if (conclude) begin
        dtype_q <= dt_new;
      end else if (!active_d) begin
        dtype_q <= DT_NONE;
      end
      // a new event beats a clear in the same cycle
      ev_q <= (ev_q & ~ev_clr) | ev_set;
      if (WR && sel_ctrl) begin
        ctrl_q <= ctrl_t'(WDATA[$bits(ctrl_t)-1:0]);
      end
      RDATA <= RD ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      DRIVE_OUT <= DRV_RST;
    end else if (CE) begin
      DRIVE_OUT.adc_en <= id_d == I_CONV;
      DRIVE_OUT.src_dp <= p_d == P_FWD;
      DRIVE_OUT.sink_dm <= p_d == P_FWD;
      DRIVE_OUT.src_dm <= p_d == P_REV;
      DRIVE_OUT.sink_dp <= p_d == P_REV;
      DRIVE_OUT.hi_sel <= ctrl_q.hi;
      DRIVE_OUT.lo_sel <= ctrl_q.lo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  a_drop_fast: assert property (CE && sup_drop |=> !sense_q && ev_q[EV_SDET])
    else $error("supply drop not reported at once");
  a_rise_debounced: assert property ($rose(sense_q) |->
    $past(s2_q.sup_hi) && $past(sdb_q) >= $past(db_need))
    else $error("supply sense rose before debounce");
  a_ovp_debounce: assert property ($rose(ev_q[EV_OVP]) |->
    $past(active_q) && $past(ovp_cnt_q) >= $past(ovp_need))
    else $error("over-voltage flag without debounce");
  a_fall_converts: assert property (CE && id_fall |=> DRIVE_OUT.adc_en && active_q)
    else $error("id attach did not start conversion");
  a_adc_clears: assert property (CE && conv_done && !id_fall && !id_rise |=>
    !DRIVE_OUT.adc_en && adc_st_q && adc_res_q == $past(s2_q.adc_res))
    else $error("conversion end not handled");
  a_jam_timeout: assert property ($rose(ev_q[EV_JAM]) |->
    $past(key_cnt_q) >= STUCK_TICKS)
    else $error("stuck key flagged early");
  a_recover_restart: assert property (CE && rcv_ev |=>
    ev_q[EV_RCV] && DRIVE_OUT.adc_en)
    else $error("stuck key release not handled");
  a_delay_start: assert property (CE && p_st_q == P_IDLE && sense_rise |=>
    p_st_q == P_DELAY && !DRIVE_OUT.src_dp)
    else $error("type sequence skipped delay");
  a_fwd_short: assert property (CE && fwd_set |=> fwd_q && !DRIVE_OUT.src_dp)
    else $error("forward short not latched");
  a_rev_short: assert property (CE && rev_set |=>
    rev_q && det_done_q && !DRIVE_OUT.src_dm)
    else $error("reverse short not latched");
  a_unknown_flag: assert property (CE && unk_ev |=> ev_q[EV_UNK])
    else $error("unknown accessory not flagged");
  a_attach_type: assert property (CE && conclude && dt_new != DT_NONE |=>
    ev_q[EV_ATT] && dtype_q == $past(dt_new))
    else $error("attach without device type");
  a_av_path: assert property (CE && av_ev |=>
    ev_q[EV_AV] && ev_q[EV_ATT] && dtype_q == DT_AV)
    else $error("av cable not reported");

  c_stuck: cover property ($rose(ev_q[EV_JAM]));
  c_reverse: cover property (CE && rev_set);
  c_av: cover property (CE && av_ev);
  c_unknown: cover property (CE && unk_ev);
endmodule : acc_ident

// ===== logic/acc_pkg.sv
package acc_pkg;
  localparam int RTC_HZ = 32768;
  localparam int DB_STEP_MS = 10;
  localparam int QUAL_MS = 20;
  localparam int WIN_MS = 100;
  localparam int TD_STEP_MS = 100;
  localparam int STUCK_MS = 1500;
  // rtc tick counts, rounded to the nearest tick
  localparam logic [15:0] DB_STEP = 16'((DB_STEP_MS * RTC_HZ + 500) / 1000);
  localparam logic [15:0] QUAL_TICKS = 16'((QUAL_MS * RTC_HZ + 500) / 1000);
  localparam logic [15:0] WIN_TICKS = 16'((WIN_MS * RTC_HZ + 500) / 1000);
  localparam int TD_STEP = (TD_STEP_MS * RTC_HZ + 500) / 1000;
  localparam logic [15:0] STUCK_DEF = 16'((STUCK_MS * RTC_HZ + 500) / 1000);

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_EVT = 8'h08;

  localparam int EV_ATT = 0;
  localparam int EV_UNK = 1;
  localparam int EV_SDET = 2;
  localparam int EV_OVP = 3;
  localparam int EV_JAM = 4;
  localparam int EV_RCV = 5;
  localparam int EV_AV = 6;
  localparam int EV_W = 7;

  localparam logic [3:0] DT_NONE = 4'h0;
  localparam logic [3:0] DT_USB = 4'h1;
  localparam logic [3:0] DT_UART = 4'h2;
  localparam logic [3:0] DT_AUDIO = 4'h3;
  localparam logic [3:0] DT_AV = 4'h4;
  localparam logic [3:0] DT_DCHG = 4'h5;
  localparam logic [3:0] DT_UCHG = 4'h6;

  localparam logic [4:0] ID_KEY_MIN = 5'h01;
  localparam logic [4:0] ID_KEY_MAX = 5'h09;
  localparam logic [4:0] ID_AV = 5'h0A;
  localparam logic [4:0] ID_UART = 5'h10;
  localparam logic [4:0] ID_AUDIO = 5'h14;

  typedef struct packed {
    logic [3:0] td;
    logic [1:0] ovp_db;
    logic [2:0] lo;
    logic [2:0] hi;
    logic [1:0] db;
  } ctrl_t;
  localparam ctrl_t CTRL_RST = 14'h106C;

  typedef struct packed {
    logic [3:0] dtype;
    logic active;
    logic det_done;
    logic rev;
    logic fwd;
    logic [4:0] adc_res;
    logic adc_st;
    logic id_open;
    logic sense;
  } stat_t;

  typedef struct packed {
    logic sup_hi;
    logic sup_lo;
    logic ovp;
    logic id_open;
    logic dm_win;
    logic dp_win;
    logic key_held;
    logic adc_done;
    logic [4:0] adc_res;
  } sense_t;
  localparam sense_t SENSE_RST = 13'h0200;

  typedef struct packed {
    logic adc_en;
    logic src_dp;
    logic sink_dm;
    logic src_dm;
    logic sink_dp;
    logic [2:0] hi_sel;
    logic [2:0] lo_sel;
  } drive_t;
  localparam drive_t DRV_RST = 11'h01B;

  function automatic logic [15:0] bump(input logic [15:0] c, input logic t);
    return (t && c != 16'hFFFF) ? c + 16'h0001 : c;
  endfunction : bump

  function automatic logic [15:0] db_ticks(input logic [1:0] s);
    return 16'(int'(s) * int'(DB_STEP));
  endfunction : db_ticks

  function automatic logic [15:0] ovp_ticks(input logic [1:0] s);
    return (s == 2'h0) ? 16'h0000 : 16'h0001 << s;
  endfunction : ovp_ticks

  function automatic logic [15:0] td_ticks(input logic [3:0] c);
    return 16'((int'(c) + 1) * TD_STEP);
  endfunction : td_ticks

  function automatic logic is_key(input logic [4:0] r);
    return r >= ID_KEY_MIN && r <= ID_KEY_MAX;
  endfunction : is_key

  function automatic logic [3:0] decide(input logic open, input logic [4:0] r,
                                        input logic fwd, input logic rev);
    if (open) begin
      return rev ? DT_UCHG : (fwd ? DT_DCHG : DT_USB);
    end
    if (r == ID_AV) begin
      return DT_AV;
    end
    if (r == ID_UART) begin
      return DT_UART;
    end
    if (r == ID_AUDIO || is_key(r)) begin
      return DT_AUDIO;
    end
    return DT_NONE;
  endfunction : decide
endpackage : acc_pkg

// ===== testbench/cable_model.sv
`timescale 1ns/100ps
module cable_model (
  input logic CLK, // system clock
  input logic SUPPLY_ON, // supply present on the connector
  input logic OVER_V, // supply over-voltage
  input logic ID_ATTACHED, // resistor from id to ground
  input logic [4:0] ID_CODE, // resistor code seen by the converter
  input logic KEY_DOWN, // remote key pressed
  input logic FWD_SHORT, // data lines shorted, forward
  input logic REV_SHORT, // data lines shorted, reverse
  input acc_pkg::drive_t DRIVE_IN, // analog enables from the block
  output acc_pkg::sense_t SENSE_OUT // comparators and converter
);
  import acc_pkg::*;
  logic [3:0] conv_q = 4'h0;
  logic [4:0] idle_res_q = 5'h00;
  logic conv_done;
  ////////////////////////////////////////////////////////////////////////////////
  // the result bus means nothing while idle, so it keeps changing to expose stale use
  always_ff @(posedge CLK) begin
    idle_res_q <= ~idle_res_q;
    if (!DRIVE_IN.adc_en) begin
      conv_q <= 4'h0;
    end else if (conv_q != 4'hF) begin
      conv_q <= conv_q + 4'h1;
    end
  end
  assign conv_done = conv_q >= 4'h8;
  assign SENSE_OUT.sup_hi = SUPPLY_ON;
  assign SENSE_OUT.sup_lo = !SUPPLY_ON;
  assign SENSE_OUT.ovp = OVER_V;
  assign SENSE_OUT.id_open = !ID_ATTACHED;
  assign SENSE_OUT.dm_win = FWD_SHORT && DRIVE_IN.src_dp && DRIVE_IN.sink_dm;
  assign SENSE_OUT.dp_win = REV_SHORT && DRIVE_IN.src_dm && DRIVE_IN.sink_dp;
  assign SENSE_OUT.key_held = KEY_DOWN;
  assign SENSE_OUT.adc_done = conv_done;
  assign SENSE_OUT.adc_res = !conv_done ? idle_res_q : (ID_ATTACHED ? ID_CODE : 5'h1F);
endmodule : cable_model

// ===== testbench/acc_ident_test.sv
`timescale 1ns/100ps
module acc_ident_test;
  import acc_pkg::*;
  logic CLK, SYS_RST, WR, RD, sup_on, ovp, id_att, key, fwd_sh, rev_sh;
  logic ce;
  logic [1:0] rtc_div;
  logic [7:0] ADDR;
  logic [31:0] WDATA, RDATA;
  logic [4:0] id_code;
  sense_t sense;
  drive_t drive;
  int num_errors, n_compared, cycles;
  acc_ident #(.STUCK_TICKS(16'h0010)) acc_ident_inst (.CLK(CLK), .SYS_RST(SYS_RST), .CE(ce),
    .RTC_CLK(rtc_div[1]), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SENSE_IN(sense), .DRIVE_OUT(drive));
  cable_model cable_model_inst (.CLK(CLK), .SUPPLY_ON(sup_on), .OVER_V(ovp),
    .ID_ATTACHED(id_att), .ID_CODE(id_code), .KEY_DOWN(key), .FWD_SHORT(fwd_sh),
    .REV_SHORT(rev_sh), .DRIVE_IN(drive), .SENSE_OUT(sense));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  // rtc runs at a quarter of the clock so the long windows fit the run
  always @(posedge CLK) begin
    rtc_div <= rtc_div + 2'h1;
    cycles = cycles + 1;
    if (cycles == 80000) begin
      num_errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    // read data stand only until this edge, taken before it updates
    @(posedge CLK);
    check(what, RDATA & m, exp);
  endtask : rchk
  function automatic logic [31:0] paths();
    return {28'h0, drive.src_dp, drive.sink_dm, drive.src_dm, drive.sink_dp};
  endfunction : paths
  task automatic detach();
    id_att <= 1'b0;
    idle(20);
    wr(REG_EVT, 32'h7F);
  endtask : detach
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    SYS_RST = 1'b1;
    {WR, RD, sup_on, ovp, id_att, key, fwd_sh, rev_sh} = 8'h00;
    ce = 1'b1;
    {ADDR, WDATA, id_code, rtc_div} = 47'h0;
    {num_errors, n_compared, cycles} = 96'h0;
    idle(10);
    SYS_RST <= 1'b0;
    check("drive", 32'(drive), 32'(DRV_RST));
    rchk("ctrl", REG_CTRL, 32'hFFFFFFFF, 32'(CTRL_RST));
    rchk("stat", REG_STAT, 32'hFFFFFFFF, 32'h000000FA);
    rchk("events", REG_EVT, 32'hFFFFFFFF, 32'h00000000);
    rchk("unmapped", 8'h0C, 32'hFFFFFFFF, 32'h00000000);
    // a write while the clock enable is low must be lost
    ce <= 1'b0;
    wr(REG_CTRL, 32'h00000000);
    ce <= 1'b1;
    rchk("frozen ctrl", REG_CTRL, 32'hFFFFFFFF, 32'(CTRL_RST));
    $display("test reset done");
    id_code <= ID_UART;
    id_att <= 1'b1;
    idle(6);
    check("adc on", 32'(drive.adc_en), 32'h1);
    idle(30);
    check("adc off", 32'(drive.adc_en), 32'h0);
    rchk("uart stat", REG_STAT, 32'hF8FE, 32'h2884);
    rchk("uart event", REG_EVT, 32'h7F, 32'h01);
    // over-voltage debounce of 8 ticks, supply debounce 10 ms
    wr(REG_CTRL, 32'h00000355);
    wr(REG_EVT, 32'h7F);
    check("thresholds", 32'({drive.hi_sel, drive.lo_sel}), 32'h0000002A);
    rchk("ctrl set", REG_CTRL, 32'h00003FFF, 32'h00000355);
    ovp <= 1'b1;
    idle(16);
    rchk("ovp early", REG_EVT, 32'h8, 32'h0);
    idle(40);
    rchk("ovp", REG_EVT, 32'h8, 32'h8);
    ovp <= 1'b0;
    $display("test id done");
    detach();
    id_code <= 5'h18;
    id_att <= 1'b1;
    idle(40);
    rchk("unknown", REG_EVT, 32'h3, 32'h2);
    rchk("unknown type", REG_STAT, 32'hF000, 32'h0);
    detach();
    id_code <= 5'h05;
    key <= 1'b1;
    id_att <= 1'b1;
    idle(40);
    rchk("stuck early", REG_EVT, 32'h10, 32'h0);
    idle(80);
    rchk("stuck", REG_EVT, 32'h30, 32'h10);
    id_code <= ID_AUDIO;
    key <= 1'b0;
    idle(40);
    rchk("recovered", REG_EVT, 32'h20, 32'h20);
    rchk("audio", REG_STAT, 32'hF0F8, 32'h30A0);
    $display("test key done");
    detach();
    id_code <= ID_AV;
    id_att <= 1'b1;
    idle(40);
    wr(REG_EVT, 32'h7F);
    sup_on <= 1'b1;
    idle(1150);
    rchk("sense early", REG_STAT, 32'h1, 32'h0);
    idle(250);
    rchk("sense", REG_STAT, 32'h1, 32'h1);
    rchk("supply event", REG_EVT, 32'h4, 32'h4);
    idle(13300);
    rchk("av", REG_EVT, 32'h41, 32'h41);
    rchk("av type", REG_STAT, 32'hF000, 32'h4000);
    wr(REG_EVT, 32'h7F);
    sup_on <= 1'b0;
    idle(6);
    rchk("drop", REG_EVT, 32'h4, 32'h4);
    rchk("sense drop", REG_STAT, 32'h1, 32'h0);
    $display("test av done");
    detach();
    wr(REG_CTRL, 32'h0000036C);
    wr(REG_EVT, 32'h7F);
    sup_on <= 1'b1;
    idle(12900);
    check("in delay", paths(), 32'h0);
    idle(400);
    check("forward", paths(), 32'hC);
    idle(13300);
    rchk("usb", REG_STAT, 32'hF700, 32'h1400);
    rchk("usb event", REG_EVT, 32'h3, 32'h1);
    check("usb off", paths(), 32'h0);
    sup_on <= 1'b0;
    idle(20);
    $display("test usb done");
    fwd_sh <= 1'b1;
    rev_sh <= 1'b1;
    sup_on <= 1'b1;
    idle(16220);
    check("reverse", paths(), 32'h3);
    rchk("fwd short", REG_STAT, 32'h100, 32'h100);
    idle(2920);
    rchk("charger", REG_STAT, 32'hF700, 32'h6700);
    check("charger off", paths(), 32'h0);
    $display("test charger done");
    complete_run();
  end
endmodule : acc_ident_test
